// ==== verilog/csts_top.sv ====
// register bank and control for current sharing and the internal temperature sensor
`timescale 1ns/10ps
`default_nettype none
module csts_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] factory_trim_count,
	input wire logic [3:0] monitor_adc_channel,
	input wire logic monitor_adc_done,
	input wire logic [11:0] monitor_adc_result,
	output logic first_switch_enable,
	output logic second_switch_enable,
	output logic pulse_output,
	output logic share_bus_pin_oe,
	output logic temp_sensor_enable,
	output logic sensor_route_ch14
);
	////////////////////////////////////////////////////////////////////
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == csts_pkg::OFS_SHARE_CTRL) || (a == csts_pkg::OFS_TEMP_CTRL) ||
			(a == csts_pkg::OFS_TEMP_CAL) || (a == csts_pkg::OFS_FACTORY_TEMP) ||
			(a == csts_pkg::OFS_TEMP_RESULT) || (a == csts_pkg::OFS_SHARE_STAT);
	endfunction

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer in the second access cycle
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic wr_fire;
	logic rd_setup;

	assign wr_fire = psel && penable && pready_q && pwrite;
	assign rd_setup = psel && penable && !pready_q;

	////////////////////////////////////////////////////////////////////
	// register state
	logic [1:0] mode_q, mode_d;
	logic [7:0] period_q, period_d;
	logic [7:0] duty_q, duty_d;
	logic sens_en_q, sens_en_d;
	logic [11:0] cal_q, cal_d;
	logic [11:0] ftemp_q, ftemp_d;
	logic ftemp_loaded_q, ftemp_loaded_d;
	logic [11:0] raw_q, raw_d;
	logic [11:0] corr_q, corr_d;
	logic res_valid_q, res_valid_d;

	always_comb begin
		mode_d = mode_q;
		period_d = period_q;
		duty_d = duty_q;
		sens_en_d = sens_en_q;
		cal_d = cal_q;
		ftemp_d = ftemp_q;
		ftemp_loaded_d = 1'b1;
		raw_d = raw_q;
		corr_d = corr_q;
		res_valid_d = res_valid_q;
		// factory count is caught once, the first cycle after reset release
		if (!ftemp_loaded_q) begin
			ftemp_d = factory_trim_count;
		end
		if (wr_fire) begin
			case (paddr)
				csts_pkg::OFS_SHARE_CTRL: begin
					// test field bits are not stored: it always stays 00
					mode_d = pwdata[csts_pkg::MODE_LSB +: 2];
					period_d = pwdata[csts_pkg::PERIOD_LSB +: 8];
					duty_d = pwdata[csts_pkg::DUTY_LSB +: 8];
				end
				csts_pkg::OFS_TEMP_CTRL: begin
					sens_en_d = pwdata[csts_pkg::SENSOR_EN_BIT];
				end
				csts_pkg::OFS_TEMP_CAL: begin
					cal_d = pwdata[11:0];
				end
				csts_pkg::OFS_FACTORY_TEMP: begin
					// a write here replaces the trimmed count until the next reset recaptures it
					ftemp_d = pwdata[11:0];
				end
				default: begin
				end
			endcase
		end
		// capture the sensor conversion and its calibrated value
		if (monitor_adc_done && monitor_adc_channel == csts_pkg::SENSOR_CHANNEL &&
			sens_en_q) begin
			raw_d = monitor_adc_result;
			corr_d = monitor_adc_result + cal_q;
			res_valid_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= csts_pkg::MODE_RST;
			period_q <= csts_pkg::PERIOD_RST;
			duty_q <= csts_pkg::DUTY_RST;
			sens_en_q <= csts_pkg::SENSOR_EN_RST;
			cal_q <= csts_pkg::CAL_RST;
			ftemp_q <= 12'h000;
			ftemp_loaded_q <= 1'b0;
			raw_q <= 12'h000;
			corr_q <= 12'h000;
			res_valid_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			period_q <= period_d;
			duty_q <= duty_d;
			sens_en_q <= sens_en_d;
			cal_q <= cal_d;
			ftemp_q <= ftemp_d;
			ftemp_loaded_q <= ftemp_loaded_d;
			raw_q <= raw_d;
			corr_q <= corr_d;
			res_valid_q <= res_valid_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// share mode decode; outputs follow mode_d so they move with the write edge
	csts_pwm_if pwm_bus ();
	logic sw1_q, sw1_d;
	logic sw2_q, sw2_d;
	logic pulse_q, pulse_d;
	logic oe_q, oe_d;
	logic run_q;

	always_comb begin
		sw1_d = 1'b0;
		sw2_d = 1'b0;
		case (csts_pkg::csts_mode_e'(mode_d))
			csts_pkg::CSTS_PWM_BUS: begin
				sw1_d = 1'b1;
			end
			csts_pkg::CSTS_ANALOG_BUS: begin
				sw2_d = 1'b1;
			end
			default: begin
				// both off modes leave the bus floating
			end
		endcase
		oe_d = sw1_d || sw2_d;
		// pulse only while pwm mode holds both now and next cycle
		pulse_d = sw1_d && run_q && pwm_bus.pulse;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw1_q <= 1'b0;
			sw2_q <= 1'b0;
			pulse_q <= 1'b0;
			oe_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			sw1_q <= sw1_d;
			sw2_q <= sw2_d;
			pulse_q <= pulse_d;
			oe_q <= oe_d;
			run_q <= sw1_d;
		end
	end

	assign pwm_bus.run = run_q;
	assign pwm_bus.period = period_q;
	assign pwm_bus.duty = duty_q;

	csts_pwm u_pwm (
		.pclk(pclk),
		.presetn(presetn),
		.pwm(pwm_bus)
	);

	////////////////////////////////////////////////////////////////////
	// sensor enable and converter routing
	logic route_q, route_d;
	logic sens_out_q;

	always_comb begin
		route_d = sens_en_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_q <= 1'b0;
			sens_out_q <= 1'b0;
		end else begin
			route_q <= route_d;
			sens_out_q <= sens_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read mux and answer
	always_comb begin
		pready_d = rd_setup;
		pslverr_d = rd_setup && !is_mapped(paddr);
		prdata_d = prdata_q;
		if (rd_setup) begin
			prdata_d = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					csts_pkg::OFS_SHARE_CTRL: begin
						prdata_d[csts_pkg::MODE_LSB +: 2] = mode_q;
						prdata_d[csts_pkg::PERIOD_LSB +: 8] = period_q;
						prdata_d[csts_pkg::DUTY_LSB +: 8] = duty_q;
					end
					csts_pkg::OFS_TEMP_CTRL: begin
						prdata_d[csts_pkg::SENSOR_EN_BIT] = sens_en_q;
					end
					csts_pkg::OFS_TEMP_CAL: begin
						prdata_d[11:0] = cal_q;
					end
					csts_pkg::OFS_FACTORY_TEMP: begin
						prdata_d[11:0] = ftemp_q;
					end
					csts_pkg::OFS_TEMP_RESULT: begin
						prdata_d[csts_pkg::RAW_LSB +: 12] = raw_q;
						prdata_d[csts_pkg::CORR_LSB +: 12] = corr_q;
						prdata_d[csts_pkg::RESULT_VALID_BIT] = res_valid_q;
					end
					csts_pkg::OFS_SHARE_STAT: begin
						prdata_d[3:0] = {oe_q, pulse_q, sw2_q, sw1_q};
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign first_switch_enable = sw1_q;
	assign second_switch_enable = sw2_q;
	assign pulse_output = pulse_q;
	assign share_bus_pin_oe = oe_q;
	assign temp_sensor_enable = sens_out_q;
	assign sensor_route_ch14 = route_q;
endmodule
`default_nettype wire

// ==== shared/csts_pkg.sv ====
// constants shared by the current sharing and temperature sense control block
`default_nettype none
package csts_pkg;
	localparam int ADDR_W = 8;
	localparam int ADC_W = 12;
	localparam int PWM_W = 8;
	localparam int CAL_W = 12;

	// register byte offsets
	localparam logic [7:0] OFS_SHARE_CTRL = 8'h00;
	localparam logic [7:0] OFS_TEMP_CTRL = 8'h04;
	localparam logic [7:0] OFS_TEMP_CAL = 8'h08;
	localparam logic [7:0] OFS_FACTORY_TEMP = 8'h0C;
	localparam logic [7:0] OFS_TEMP_RESULT = 8'h10;
	localparam logic [7:0] OFS_SHARE_STAT = 8'h14;

	// share control fields
	localparam int MODE_LSB = 0;
	localparam int TEST_LSB = 2;
	localparam int PERIOD_LSB = 8;
	localparam int DUTY_LSB = 16;
	// temperature control and result fields
	localparam int SENSOR_EN_BIT = 0;
	localparam int RAW_LSB = 0;
	localparam int CORR_LSB = 16;
	localparam int RESULT_VALID_BIT = 31;

	// monitor converter input that carries the sensor
	localparam logic [3:0] SENSOR_CHANNEL = 4'hE;

	// values after reset
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [11:0] CAL_RST = 12'h000;
	localparam logic SENSOR_EN_RST = 1'b0;

	typedef enum logic [1:0] {
		CSTS_OFF_A = 2'b00,
		CSTS_PWM_BUS = 2'b01,
		CSTS_OFF_B = 2'b10,
		CSTS_ANALOG_BUS = 2'b11
	} csts_mode_e;
endpackage
`default_nettype wire

// ==== shared/csts_pwm_if.sv ====
// carrier between the register bank and the share current source pwm
`timescale 1ns/10ps
`default_nettype none
interface csts_pwm_if;
	logic run;
	logic [7:0] period;
	logic [7:0] duty;
	logic pulse;
	modport ctl (output run, output period, output duty, input pulse);
	modport gen (input run, input period, input duty, output pulse);
endinterface
`default_nettype wire

// ==== verilog/csts_pwm.sv ====
// 8-bit pwm that drives the share current source
`timescale 1ns/10ps
`default_nettype none
module csts_pwm (
	input wire logic pclk,
	input wire logic presetn,
	csts_pwm_if.gen pwm
);
	logic [7:0] cnt_q, cnt_d;
	logic pulse_q, pulse_d;

	always_comb begin
		cnt_d = cnt_q;
		pulse_d = 1'b0;
		if (!pwm.run) begin
			// restart from zero so each enable begins a clean period
			cnt_d = 8'h00;
		end else begin
			if (cnt_q >= pwm.period) begin
				cnt_d = 8'h00;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
			pulse_d = (cnt_q < pwm.duty);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			pulse_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign pwm.pulse = pulse_q;
endmodule
`default_nettype wire

// ==== tb/csts_assertions.sv ====
// concurrent checks on the share and sensor outputs of the register block
`timescale 1ns/10ps
`default_nettype none
module csts_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic first_switch_enable,
	input wire logic second_switch_enable,
	input wire logic pulse_output,
	input wire logic share_bus_pin_oe,
	input wire logic temp_sensor_enable,
	input wire logic sensor_route_ch14
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_share;
	logic wr_temp;
	assign wr_share = psel && penable && pready && pwrite && paddr == csts_pkg::OFS_SHARE_CTRL;
	assign wr_temp = psel && penable && pready && pwrite && paddr == csts_pkg::OFS_TEMP_CTRL;
	////////////////////////////////////////////////////////////////
	a_mode_pwm: assert property (wr_share && pwdata[1:0] == 2'b01 |=>
		first_switch_enable && !second_switch_enable && share_bus_pin_oe) else $error("pwm mode");
	a_mode_analog: assert property (wr_share && pwdata[1:0] == 2'b11 |=>
		!first_switch_enable && second_switch_enable) else $error("analog mode");
	a_mode_off: assert property (wr_share && !pwdata[0] |=>
		!first_switch_enable && !second_switch_enable && !share_bus_pin_oe) else $error("off mode");
	a_oe_follows_sw: assert property (share_bus_pin_oe ==
		(first_switch_enable || second_switch_enable)) else $error("oe mismatch");
	a_pulse_gated: assert property (!first_switch_enable [*2] |-> !pulse_output)
		else $error("pulse outside pwm mode");
	a_sw_on_write: assert property ($changed({first_switch_enable, second_switch_enable})
		|-> $past(wr_share)) else $error("switch moved without write");
	a_sensor_write: assert property (wr_temp |=> temp_sensor_enable == $past(pwdata[0]))
		else $error("sensor enable");
	a_route_match: assert property (sensor_route_ch14 == temp_sensor_enable)
		else $error("route mismatch");
	c_pwm: cover property (wr_share && pwdata[1:0] == 2'b01);
	c_analog: cover property (wr_share && pwdata[1:0] == 2'b11);
	c_pulse: cover property ($rose(pulse_output));
endmodule
`default_nettype wire

// ==== tb/csts_top_tb.sv ====
// self-checking bench for the share and temperature register block
`timescale 1ns/10ps
`default_nettype none
module csts_top_tb;
	typedef struct {logic [1:0] m; logic [3:0] st; int np;} csts_row_s;
	logic pclk, presetn, psel, penable, pwrite, adc_done, pready, pslverr, e;
	logic sw1, sw2, pls, oe, ten, rte;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] ch;
	logic [11:0] res;
	int fail_count, n_checks, k, cnt;
	csts_row_s rows[4];
	csts_top i_csts_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .factory_trim_count(12'h0A5C), .monitor_adc_channel(ch),
		.monitor_adc_done(adc_done), .monitor_adc_result(res), .first_switch_enable(sw1),
		.second_switch_enable(sw2), .pulse_output(pls), .share_bus_pin_oe(oe),
		.temp_sensor_enable(ten), .sensor_route_ch14(rte));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count is assumed here: only the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		finish_test;
	end
	initial begin
		rows[0] = '{2'b00, 4'h0, 0};
		rows[1] = '{2'b01, 4'h9, 10};
		rows[2] = '{2'b10, 4'h0, 0};
		rows[3] = '{2'b11, 4'hA, 0};
		{presetn, psel, penable, pwrite, adc_done, paddr, pwdata, ch, res} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000_FF00);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0);
		// the factory count is writable, but this bench only ever reads it
		apb(1'b0, 8'h0C, 32'h0);
		chk(r, 32'h0000_0A5C);
		// period 3, duty 1: one high cycle in every four
		for (k = 0; k < 4; k++) begin
			apb(1'b1, 8'h00, {16'h0001, 8'h03, 6'h00, rows[k].m});
			apb(1'b0, 8'h00, 32'h0);
			chk(r, {16'h0001, 8'h03, 6'h00, rows[k].m});
			apb(1'b0, 8'h14, 32'h0);
			chk(r & 32'hFFFF_FFFB, {28'h0, rows[k].st});
			cnt = 0;
			repeat (40) begin
				@(posedge pclk);
				if (pls === 1'b1)
					cnt++;
			end
			chk(cnt, rows[k].np);
		end
		apb(1'b1, 8'h04, 32'h1);
		// the outputs move on the write edge itself, so look just after it
		#1 chk({ten, rte}, 32'h3);
		apb(1'b1, 8'h08, 32'h0000_0010);
		@(posedge pclk);
		{adc_done, ch, res} <= {1'b1, 4'hE, 12'h300};
		// a later conversion on another input must not overwrite the capture
		@(posedge pclk);
		{ch, res} <= {4'hD, 12'h111};
		@(posedge pclk);
		adc_done <= 1'b0;
		apb(1'b0, 8'h10, 32'h0);
		chk(r, 32'h8310_0300);
		apb(1'b1, 8'h04, 32'h0);
		#1 chk({ten, rte}, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(e, 32'h1);
		chk(r, 32'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1 chk({sw1, sw2, oe, pls, ten}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000_FF00);
		finish_test;
	end
endmodule
bind csts_top csts_assertions i_csts_assertions (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .first_switch_enable, .second_switch_enable, .pulse_output,
	.share_bus_pin_oe, .temp_sensor_enable, .sensor_route_ch14);
`default_nettype wire
